// >>> verification/testbench.sv
// Self-checking bench of the serial port driving a single-wire slave
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic [7:0]   CMD = 8'h33;
   logic                    clk;
   logic                    rst_n;
   uart_wire_pkg::bus_req_t req;
   logic [7:0]              rdata;
   logic                    sout;
   logic                    pull;
   logic                    line;
   logic                    dtr, rts, out1, out2;
   logic [7:0]              cmd;
   logic [63:0]             id;
   logic [7:0]              v;
   logic [7:0]              d;
   int                      num_errors = 0;
   int                      n_tests = 0;
   // Open-drain wire with pull-up, no inversion either way
   assign line = sout & !pull;
   uart_wire_port i_uart_wire_port (.i_core_clk(clk), .i_rst_n(rst_n), .i_bus_req(req),
      .o_rdata(rdata), .o_serial_out(sout), .i_serial_in(line), .o_dtr(dtr), .o_rts(rts),
      .o_out1(out1), .o_out2(out2));
   wire_slave_model i_wire_slave_model (.i_core_clk(clk), .i_line(line), .i_id(id),
      .o_pull(pull), .o_cmd(cmd));
   initial begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   // ----------------------------------------------------------------
   // Bus cycles, comparison and expectations
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] dd);
      @(negedge clk);
      req = '{sel: 1'b1, wr: w, rd: !w, addr: a, wdata: dd};
      @(negedge clk);
      req = '0;
   endtask
   task automatic slot(input logic [7:0] c, output logic [7:0] q);
      int i;
      acc(1'b1, 3'h0, c);
      for (i = 0; i < 3000; i++) begin
         acc(1'b0, 3'h5, 8'h00);
         if (rdata[0] === 1'b1) break;
      end
      if (i == 3000) begin
         chk("data ready wait", 8'h01, 8'h00);
         conclude();
      end
      acc(1'b0, 3'h0, 8'h00);
      q = rdata;
   endtask
   function automatic logic [7:0] exp_reg(input int a, input logic [7:0] w, input bit wrote);
      case (a)
         1: return wrote ? {4'h0, w[3:0]} : 8'h00;
         2: return 8'h01;
         3: return wrote ? w : 8'h00;
         4: return wrote ? {3'h0, w[4:0]} : 8'h00;
         5: return 8'h60;
         default: return 8'h00;
      endcase
   endfunction
   initial begin
      req = '0;
      rst_n = 1'b0;
      d = 8'h00;
      v = $urandom(32'hbf47);
      id = {$urandom, $urandom};
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int a = 1; a < 8; a++) begin
         acc(1'b0, a[2:0], 8'h00);
         chk("reset value", exp_reg(a, 8'h00, 1'b0), rdata);
      end
      for (int a = 1; a < 8; a++) begin
         d = $urandom;
         d = (a == 3) ? (d & 8'h3f) : (a == 4) ? (d & 8'hef) : d;
         acc(1'b1, a[2:0], d);
         acc(1'b0, a[2:0], 8'h00);
         chk("read back", exp_reg(a, d, 1'b1), rdata);
         if (a == 4) chk("modem pins", {4'h0, d[3:0]}, {4'h0, out2, out1, rts, dtr});
      end
      acc(1'b1, 3'h3, 8'h83);
      acc(1'b1, 3'h0, 8'h0b);
      acc(1'b1, 3'h1, 8'h00);
      acc(1'b0, 3'h0, 8'h00);
      chk("divisor low", 8'h0b, rdata);
      acc(1'b1, 3'h3, 8'h03);
      slot(8'hf0, v);
      chk("reset echo low", 8'h00, {4'h0, v[3:0]});
      if (v[7:4] === 4'hf) chk("presence", 8'h00, v);
      acc(1'b1, 3'h3, 8'h83);
      acc(1'b1, 3'h0, 8'h01);
      acc(1'b1, 3'h3, 8'h03);
      for (int b = 0; b < 8; b++) begin
         slot(CMD[b] ? 8'hff : 8'h00, v);
         chk("slot echo", CMD[b] ? 8'hff : 8'h00, v);
      end
      chk("command", CMD, cmd);
      for (int j = 0; j < 8; j++) begin
         for (int b = 0; b < 8; b++) begin
            slot(8'hff, v);
            d[b] = v[0];
         end
         chk("identity byte", id[8*j +: 8], d);
      end
      acc(1'b1, 3'h4, 8'h10);
      acc(1'b1, 3'h3, 8'h1f);
      for (int k = 0; k < 17; k++) begin
         acc(1'b1, 3'h0, 8'hff);
         repeat (200) @(negedge clk);
      end
      acc(1'b0, 3'h5, 8'h00);
      chk("overrun status", 8'h63, rdata);
      for (int k = 0; k < 16; k++) begin
         acc(1'b0, 3'h0, 8'h00);
         chk("fifo data", 8'hff, rdata);
      end
      acc(1'b0, 3'h5, 8'h00);
      chk("drained status", 8'h60, rdata);
      acc(1'b0, 3'h0, 8'h00);
      chk("empty read", 8'h00, rdata);
      conclude();
   end
endmodule
`default_nettype wire

// >>> verification/uart_wire_port_assertions.sv
// Concurrent checks on the serial port's register and line ports
`timescale 1ns/100ps
`default_nettype none
module uart_wire_port_assertions (
   input wire logic                    i_core_clk,
   input wire logic                    i_rst_n,
   input wire uart_wire_pkg::bus_req_t i_bus_req,
   input wire logic [7:0]              o_rdata,
   input wire logic                    o_serial_out,
   input wire logic                    i_serial_in,
   input wire logic                    o_dtr,
   input wire logic                    o_rts,
   input wire logic                    o_out1,
   input wire logic                    o_out2
);
   // ----------------------------------------------------------------
   // Register and line properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   logic rd;
   logic wr;
   assign rd = i_bus_req.sel && i_bus_req.rd;
   assign wr = i_bus_req.sel && i_bus_req.wr;
   irq_id_fixed_a: assert property (rd && i_bus_req.addr == 3'h2 |=> o_rdata == 8'h01)
      else $error("irq ident read wrong");
   slot_seven_a: assert property (rd && i_bus_req.addr == 3'h7 |=> o_rdata == 8'h00)
      else $error("empty slot read not zero");
   modem_stat_a: assert property (rd && i_bus_req.addr == 3'h6 |=> o_rdata == 8'h00)
      else $error("modem status read not zero");
   rdata_hold_a: assert property (!rd |=> $stable(o_rdata))
      else $error("read data moved without a read");
   modem_pins_a: assert property (wr && i_bus_req.addr == 3'h4 |=>
      {o_out2, o_out1, o_rts, o_dtr} == $past(i_bus_req.wdata[3:0]))
      else $error("modem pins differ from write");
   start_len_a: assert property ($fell(o_serial_out) |-> (!o_serial_out) [*8])
      else $error("start bit too short");
   status_top_a: assert property (rd && i_bus_req.addr == 3'h5 |=> !o_rdata[7])
      else $error("line status top bit set");
   mcr_top_a: assert property (rd && i_bus_req.addr == 3'h4 |=> o_rdata[7:5] == 3'h0)
      else $error("modem control top bits set");
   cover property (rd && i_bus_req.addr == 3'h5 ##1 o_rdata[1]);
   cover property ($fell(o_serial_out));
   cover property (rd && i_bus_req.addr == 3'h0 ##1 !o_rdata[0]);
endmodule
bind uart_wire_port uart_wire_port_assertions i_uart_wire_port_assertions (
   .i_core_clk, .i_rst_n, .i_bus_req, .o_rdata, .o_serial_out,
   .i_serial_in, .o_dtr, .o_rts, .o_out1, .o_out2);
`default_nettype wire

// >>> verification/wire_slave_model.sv
// Behavioural single-wire slave: presence, command capture, identity bits
`timescale 1ns/100ps
`default_nettype none
module wire_slave_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_line,
   input  wire logic [63:0] i_id,
   output logic             o_pull,
   output logic [7:0]       o_cmd
);
   // ----------------------------------------------------------------
   // Slot timing from the falling edge
   // ----------------------------------------------------------------
   logic        prev_ff = 1'b1;
   logic [15:0] low_ff = 16'h0;
   logic [15:0] t_ff = 16'h0;
   logic [7:0]  pc_ff = 8'h0;
   logic [6:0]  nbit_ff = 7'h0;
   always @(posedge i_core_clk) begin
      prev_ff <= i_line;
      low_ff <= i_line ? 16'h0 : low_ff + 16'h1;
      if (prev_ff && !i_line) t_ff <= 16'h0;
      else if (t_ff != 16'hffff) t_ff <= t_ff + 16'h1;
      if (pc_ff != 8'h0) pc_ff <= pc_ff + 8'h1;
      if (i_line && low_ff > 16'd400) begin
         pc_ff <= 8'h1;
         nbit_ff <= 7'h0;
      end else if (pc_ff == 8'h0 && t_ff == 16'd60 && nbit_ff < 7'd72) begin
         nbit_ff <= nbit_ff + 7'h1;
         if (nbit_ff < 7'd8) o_cmd <= {i_line, o_cmd[7:1]};
      end
   end
   always_comb begin
      o_pull = pc_ff >= 8'd20 && pc_ff < 8'd120;
      if (pc_ff == 8'h0 && nbit_ff >= 7'd8 && nbit_ff < 7'd72 && t_ff < 16'd40)
         o_pull = !i_id[nbit_ff - 7'd8];
   end
endmodule
`default_nettype wire

// >>> verilog/char_fifo.sv
// Receive character FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("char_fifo needs a power of two depth of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_ff;
   logic [AW:0]      nxt_wr_ptr;
   logic [AW:0]      rd_ptr_ff;
   logic [AW:0]      nxt_rd_ptr;
   logic             push;
   logic             pop;

   // ----------------------------------------------------------------
   // Pointers
   // ----------------------------------------------------------------
   always_comb begin
      o_in_ready  = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
      o_out_valid = wr_ptr_ff != rd_ptr_ff;
      o_out_data  = mem[rd_ptr_ff[AW-1:0]];
      push        = i_in_valid & o_in_ready;
      pop         = i_out_ready & o_out_valid;
      nxt_wr_ptr  = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      nxt_rd_ptr  = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/uart_wire_pkg.sv
// Shared constants and carriers of the byte-wide serial port
package uart_wire_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] OFS_DATA       = 3'h0;
   localparam logic [2:0] OFS_IRQ_EN     = 3'h1;
   localparam logic [2:0] OFS_IRQ_ID     = 3'h2;
   localparam logic [2:0] OFS_LINE_CTRL  = 3'h3;
   localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
   localparam logic [2:0] OFS_LINE_STAT  = 3'h5;
   localparam logic [2:0] OFS_MODEM_STAT = 3'h6;

   // ----------------------------------------------------------------
   // Values after reset and fixed read values
   // ----------------------------------------------------------------
   localparam logic [7:0]  DIV_LO_RESET     = 8'h01;
   localparam logic [7:0]  DIV_HI_RESET     = 8'h00;
   localparam logic [3:0]  IRQ_EN_RESET     = 4'h0;
   localparam logic [7:0]  LINE_CTRL_RESET  = 8'h00;
   localparam logic [7:0]  MODEM_CTRL_RESET = 8'h00;
   localparam logic [7:0]  IRQ_ID_VALUE     = 8'h01;
   localparam logic [7:0]  MODEM_STAT_VALUE = 8'h00;
   localparam logic [7:0]  UNMAPPED_VALUE   = 8'h00;

   // ----------------------------------------------------------------
   // Bit timing: sixteen baud ticks per bit
   // ----------------------------------------------------------------
   localparam logic [3:0]  TICK_LAST = 4'hf;
   localparam logic [3:0]  TICK_MID  = 4'h7;
   localparam logic [2:0]  MIN_BITS_LAST = 3'h4;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       divisor_access_select;
      logic       set_break;
      logic       stick_parity;
      logic       even_parity;
      logic       parity_en;
      logic       two_stop;
      logic [1:0] word_len;
   } line_ctrl_t;

   typedef struct packed {
      logic [2:0] zero;
      logic       loop;
      logic       out2;
      logic       out1;
      logic       rts;
      logic       dtr;
   } modem_ctrl_t;

   typedef struct packed {
      logic zero;
      logic tx_shift_empty;
      logic tx_hold_empty;
      logic break_int;
      logic framing_err;
      logic parity_err;
      logic overrun_err;
      logic data_ready;
   } line_stat_t;

   typedef struct packed {
      logic       sel;
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

endpackage

// >>> verilog/uart_wire_port.sv
// Byte-wide serial port that frames one character per bus time slot
//
// Notes on behaviour
// R1: Programmable divisor lets software pick a fast rate, one character per slot.
// R2: Software splits bytes into bits, least significant first, one character each.
// R3: Software rebuilds bytes from received characters, least significant first.
// R4: Writing transmit register starts a character; port times it unaided.
// R5: Status flags show transmit done and received data available.
// R6: Baud rate, word length, parity and stop bits are programmable.
// R7: Identity read is reset, then command 33H least significant bit first.
// R8: Identity read then needs exactly 64 read slots.
// R9: Software-timed masters branch only on an idle bus, other interrupts off.
// R10: Bus is driven through an open-drain stage, output complemented if inverting.
// R11: An inverting input comparator is compensated by re-inverting samples.
// R12: Logic 0 is the start bit level; logic 1 is stop and idle.
// R13: Path is polarity transparent: a written 1 is sent and read as 1.
// R14: Eight byte locations selected by three address bits, byte wide.
// R15: Only offsets zero to six hold registers; offset seven is empty.
// R16: Offset zero reads received data and writes the transmit character.
// R17: Offset two is read only; writes to it are ignored.
// R18: Only the two modem control outputs are needed; the port drives four: dtr, rts, out1 and out2.
// R19: Bring-up starts with reset pulses and presence, then write slots.
// R20: Low under 15 us writes a one, at least 60 us writes a zero.
// R21: Reset cycle sends F0 at 10473 bps; other echo means presence.
// R22: Fast slots send 00 for zero, FF for one or read; bit in echo LSB.
`timescale 1ns/100ps
`default_nettype none
module uart_wire_port #(
   parameter int RX_DEPTH = 16
) (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst_n,
   input  wire uart_wire_pkg::bus_req_t   i_bus_req,
   output logic                     [7:0] o_rdata,
   output logic                           o_serial_out,
   input  wire logic                      i_serial_in,
   output logic                           o_dtr,
   output logic                           o_rts,
   output logic                           o_out1,
   output logic                           o_out2
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   uart_wire_pkg::line_ctrl_t  lcr_ff, nxt_lcr;
   uart_wire_pkg::modem_ctrl_t mcr_ff, nxt_mcr;
   uart_wire_pkg::line_stat_t  lsr;
   logic [7:0]  dll_ff, nxt_dll, dlm_ff, nxt_dlm, rdata_ff, nxt_rdata;
   logic [3:0]  ier_ff, nxt_ier;
   logic        oe_ff, nxt_oe, pe_ff, nxt_pe, fe_ff, nxt_fe, bi_ff, nxt_bi;
   logic        wr_hit, rd_hit, wr_thr, rd_rbr, rd_lsr;
   logic [15:0] divisor, baud_cnt_ff, nxt_baud_cnt;
   logic        tick_ff, nxt_tick;
   tx_state_t   tx_state_ff, nxt_tx_state;
   logic [7:0]  thr_ff, nxt_thr, tx_shift_ff, nxt_tx_shift;
   logic        thr_full_ff, nxt_thr_full, tx_par_ff, nxt_tx_par;
   logic        tx_line_ff, nxt_tx_line, serial_ff, nxt_serial;
   logic [3:0]  tx_tick_ff, nxt_tx_tick;
   logic [2:0]  tx_bit_ff, nxt_tx_bit;
   rx_state_t   rx_state_ff, nxt_rx_state;
   logic        rx_meta_ff, rx_sync_ff, rx_prev_ff, rx_in;
   logic [7:0]  rx_shift_ff, nxt_rx_shift, rx_data;
   logic [3:0]  rx_tick_ff, nxt_rx_tick;
   logic [2:0]  rx_bit_ff, nxt_rx_bit;
   logic        rx_par_ff, nxt_rx_par;
   logic        rx_done, rx_fe, rx_pe, rx_bi, fifo_in_ready, fifo_valid;
   logic [7:0]  fifo_head;
   logic [2:0]  bits_last;

   function automatic logic calc_parity(input logic [7:0] d,
                                        input uart_wire_pkg::line_ctrl_t c);
      logic [7:0] mask;
      mask = 8'hff >> (2'h3 - c.word_len);
      if (c.stick_parity) begin
         calc_parity = ~c.even_parity;
      end else begin
         calc_parity = c.even_parity ? ^(d & mask) : ~^(d & mask);
      end
   endfunction

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_comb begin
      wr_hit    = i_bus_req.sel & i_bus_req.wr;
      rd_hit    = i_bus_req.sel & i_bus_req.rd;
      wr_thr    = wr_hit & (i_bus_req.addr == uart_wire_pkg::OFS_DATA)
                  & ~lcr_ff.divisor_access_select; // R16
      rd_rbr    = rd_hit & (i_bus_req.addr == uart_wire_pkg::OFS_DATA)
                  & ~lcr_ff.divisor_access_select; // R16
      rd_lsr    = rd_hit & (i_bus_req.addr == uart_wire_pkg::OFS_LINE_STAT);
      bits_last = uart_wire_pkg::MIN_BITS_LAST + {1'b0, lcr_ff.word_len};
      lsr       = '{zero: 1'b0, tx_shift_empty: ~thr_full_ff & (tx_state_ff == TX_IDLE),
                    tx_hold_empty: ~thr_full_ff, break_int: bi_ff, framing_err: fe_ff,
                    parity_err: pe_ff, overrun_err: oe_ff, data_ready: fifo_valid}; // R5
      nxt_lcr   = lcr_ff;
      nxt_mcr   = mcr_ff;
      nxt_dll   = dll_ff;
      nxt_dlm   = dlm_ff;
      nxt_ier   = ier_ff;
      nxt_rdata = rdata_ff;
      if (wr_hit) begin
         unique case (i_bus_req.addr) // R14
            uart_wire_pkg::OFS_DATA: begin
               if (lcr_ff.divisor_access_select) nxt_dll = i_bus_req.wdata;
            end
            uart_wire_pkg::OFS_IRQ_EN: begin
               if (lcr_ff.divisor_access_select) nxt_dlm = i_bus_req.wdata;
               else nxt_ier = i_bus_req.wdata[3:0];
            end
            uart_wire_pkg::OFS_LINE_CTRL:  nxt_lcr = i_bus_req.wdata; // R6
            uart_wire_pkg::OFS_MODEM_CTRL: nxt_mcr = {3'h0, i_bus_req.wdata[4:0]}; // R18
            default: ; // R17 R15
         endcase
      end
      if (rd_hit) begin
         unique case (i_bus_req.addr)
            uart_wire_pkg::OFS_DATA: nxt_rdata = lcr_ff.divisor_access_select ? dll_ff
                                                 : (fifo_valid ? fifo_head : 8'h00); // R16
            uart_wire_pkg::OFS_IRQ_EN: nxt_rdata = lcr_ff.divisor_access_select ? dlm_ff
                                                   : {4'h0, ier_ff};
            uart_wire_pkg::OFS_IRQ_ID:     nxt_rdata = uart_wire_pkg::IRQ_ID_VALUE; // R17
            uart_wire_pkg::OFS_LINE_CTRL:  nxt_rdata = lcr_ff;
            uart_wire_pkg::OFS_MODEM_CTRL: nxt_rdata = mcr_ff;
            uart_wire_pkg::OFS_LINE_STAT:  nxt_rdata = lsr; // R5
            uart_wire_pkg::OFS_MODEM_STAT: nxt_rdata = uart_wire_pkg::MODEM_STAT_VALUE;
            default:                       nxt_rdata = uart_wire_pkg::UNMAPPED_VALUE; // R15
         endcase
      end
      // Status read clears errors, a new error in the same cycle wins
      nxt_oe = (oe_ff & ~rd_lsr) | (rx_done & ~fifo_in_ready);
      nxt_fe = (fe_ff & ~rd_lsr) | (rx_done & rx_fe);
      nxt_pe = (pe_ff & ~rd_lsr) | (rx_done & rx_pe);
      nxt_bi = (bi_ff & ~rd_lsr) | (rx_done & rx_bi);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lcr_ff   <= uart_wire_pkg::LINE_CTRL_RESET;
         mcr_ff   <= uart_wire_pkg::MODEM_CTRL_RESET;
         dll_ff   <= uart_wire_pkg::DIV_LO_RESET;
         dlm_ff   <= uart_wire_pkg::DIV_HI_RESET;
         ier_ff   <= uart_wire_pkg::IRQ_EN_RESET;
         rdata_ff <= 8'h00;
         oe_ff    <= 1'b0;
         fe_ff    <= 1'b0;
         pe_ff    <= 1'b0;
         bi_ff    <= 1'b0;
      end else begin
         lcr_ff   <= nxt_lcr;
         mcr_ff   <= nxt_mcr;
         dll_ff   <= nxt_dll;
         dlm_ff   <= nxt_dlm;
         ier_ff   <= nxt_ier;
         rdata_ff <= nxt_rdata;
         oe_ff    <= nxt_oe;
         fe_ff    <= nxt_fe;
         pe_ff    <= nxt_pe;
         bi_ff    <= nxt_bi;
      end
   end

   // ----------------------------------------------------------------
   // Baud tick, sixteen per bit
   // ----------------------------------------------------------------
   always_comb begin
      divisor      = {dlm_ff, dll_ff}; // R1
      nxt_tick     = baud_cnt_ff == 16'h0000;
      nxt_baud_cnt = baud_cnt_ff - 16'h0001;
      if (nxt_tick) begin
         nxt_baud_cnt = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         baud_cnt_ff <= 16'h0000;
         tick_ff     <= 1'b0;
      end else begin
         baud_cnt_ff <= nxt_baud_cnt;
         tick_ff     <= nxt_tick;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   always_comb begin
      nxt_tx_state = tx_state_ff;
      nxt_thr      = thr_ff;
      nxt_thr_full = thr_full_ff;
      nxt_tx_shift = tx_shift_ff;
      nxt_tx_par   = tx_par_ff;
      nxt_tx_line  = tx_line_ff;
      nxt_tx_tick  = tx_tick_ff;
      nxt_tx_bit   = tx_bit_ff;
      if (tx_state_ff == TX_IDLE) begin
         if (thr_full_ff) begin // R4
            nxt_tx_shift = thr_ff;
            nxt_tx_par   = calc_parity(thr_ff, lcr_ff);
            nxt_thr_full = 1'b0;
            nxt_tx_state = TX_START;
            nxt_tx_tick  = 4'h0;
            nxt_tx_line  = 1'b0; // R12
         end
      end else if (tick_ff) begin
         nxt_tx_tick = tx_tick_ff + 4'h1;
         if (tx_tick_ff == uart_wire_pkg::TICK_LAST) begin
            unique case (tx_state_ff)
               TX_START: begin
                  nxt_tx_state = TX_DATA;
                  nxt_tx_bit   = 3'h0;
                  nxt_tx_line  = tx_shift_ff[0]; // R13 R2
               end
               TX_DATA: begin
                  nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
                  nxt_tx_bit   = tx_bit_ff + 3'h1;
                  nxt_tx_line  = tx_shift_ff[1];
                  if (tx_bit_ff == bits_last) begin // R6
                     nxt_tx_bit   = 3'h0;
                     nxt_tx_state = lcr_ff.parity_en ? TX_PAR : TX_STOP;
                     nxt_tx_line  = lcr_ff.parity_en ? tx_par_ff : 1'b1;
                  end
               end
               TX_PAR: begin
                  nxt_tx_state = TX_STOP;
                  nxt_tx_line  = 1'b1; // R12
               end
               TX_STOP: begin
                  nxt_tx_bit = tx_bit_ff + 3'h1;
                  if (tx_bit_ff == {2'h0, lcr_ff.two_stop}) begin
                     nxt_tx_state = TX_IDLE;
                  end
               end
               TX_IDLE: ;
            endcase
         end
      end
      if (wr_thr) begin
         nxt_thr      = i_bus_req.wdata;
         nxt_thr_full = 1'b1;
      end
      nxt_serial = mcr_ff.loop | (~lcr_ff.set_break & tx_line_ff); // R12
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_state_ff <= TX_IDLE;
         thr_ff      <= 8'h00;
         thr_full_ff <= 1'b0;
         tx_shift_ff <= 8'h00;
         tx_par_ff   <= 1'b0;
         tx_line_ff  <= 1'b1;
         serial_ff   <= 1'b1;
         tx_tick_ff  <= 4'h0;
         tx_bit_ff   <= 3'h0;
      end else begin
         tx_state_ff <= nxt_tx_state;
         thr_ff      <= nxt_thr;
         thr_full_ff <= nxt_thr_full;
         tx_shift_ff <= nxt_tx_shift;
         tx_par_ff   <= nxt_tx_par;
         tx_line_ff  <= nxt_tx_line;
         serial_ff   <= nxt_serial;
         tx_tick_ff  <= nxt_tx_tick;
         tx_bit_ff   <= nxt_tx_bit;
      end
   end

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   always_comb begin
      rx_in        = mcr_ff.loop ? tx_line_ff : rx_sync_ff;
      nxt_rx_state = rx_state_ff;
      nxt_rx_shift = rx_shift_ff;
      nxt_rx_tick  = rx_tick_ff;
      nxt_rx_bit   = rx_bit_ff;
      nxt_rx_par   = rx_par_ff;
      rx_done      = 1'b0;
      rx_data      = rx_shift_ff >> (2'h3 - lcr_ff.word_len); // R13
      rx_fe        = ~rx_in;
      rx_pe        = lcr_ff.parity_en & (rx_par_ff != calc_parity(rx_data, lcr_ff));
      rx_bi        = (rx_data == 8'h00) & ~rx_par_ff & ~rx_in;
      if (rx_state_ff == RX_IDLE) begin
         if (rx_prev_ff & ~rx_in) begin // R12
            nxt_rx_state = RX_START;
            nxt_rx_tick  = 4'h0;
         end
      end else if (tick_ff) begin
         nxt_rx_tick = rx_tick_ff + 4'h1;
         unique case (rx_state_ff)
            RX_START: begin
               if (rx_tick_ff == uart_wire_pkg::TICK_MID) begin
                  nxt_rx_tick  = 4'h0;
                  nxt_rx_bit   = 3'h0;
                  nxt_rx_state = rx_in ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_tick_ff == uart_wire_pkg::TICK_LAST) begin
                  nxt_rx_shift = {rx_in, rx_shift_ff[7:1]}; // R3
                  nxt_rx_bit   = rx_bit_ff + 3'h1;
                  if (rx_bit_ff == bits_last) begin
                     nxt_rx_state = lcr_ff.parity_en ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (rx_tick_ff == uart_wire_pkg::TICK_LAST) begin
                  nxt_rx_par   = rx_in;
                  nxt_rx_state = RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_tick_ff == uart_wire_pkg::TICK_LAST) begin
                  rx_done      = 1'b1; // R5
                  nxt_rx_par   = 1'b0;
                  nxt_rx_state = RX_IDLE;
               end
            end
            RX_IDLE: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_meta_ff  <= 1'b1;
         rx_sync_ff  <= 1'b1;
         rx_prev_ff  <= 1'b1;
         rx_state_ff <= RX_IDLE;
         rx_shift_ff <= 8'h00;
         rx_tick_ff  <= 4'h0;
         rx_bit_ff   <= 3'h0;
         rx_par_ff   <= 1'b0;
      end else begin
         rx_meta_ff  <= i_serial_in;
         rx_sync_ff  <= rx_meta_ff;
         rx_prev_ff  <= rx_in;
         rx_state_ff <= nxt_rx_state;
         rx_shift_ff <= nxt_rx_shift;
         rx_tick_ff  <= nxt_rx_tick;
         rx_bit_ff   <= nxt_rx_bit;
         rx_par_ff   <= nxt_rx_par;
      end
   end

   // ----------------------------------------------------------------
   // Received characters wait here until software reads them
   // ----------------------------------------------------------------
   char_fifo #(
      .WIDTH (8),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (rx_done),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (rx_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (rd_rbr),
      .o_out_data  (fifo_head)
   );

   assign o_rdata      = rdata_ff;
   assign o_serial_out = serial_ff;
   assign o_dtr        = mcr_ff.dtr;
   assign o_rts        = mcr_ff.rts;
   assign o_out1       = mcr_ff.out1;
   assign o_out2       = mcr_ff.out2;
endmodule
`default_nettype wire
